// ---- pis_pkg.sv ----
package pis_pkg;

  localparam int PIS_GROUPS    = 17;
  localparam int PIS_LEVELS    = 16;
  localparam int PIS_EXT_LINES = 256;
  localparam int PIS_LINE_W    = 9;

  // condition flag layout
  localparam int FLG_LESS     = 0;
  localparam int FLG_OVF      = 1;
  localparam int FLG_CARRY    = 2;
  localparam int FLG_BUSY     = 3;
  localparam int FLG_ENABLE   = 4;
  localparam int FLG_ZERO     = 5;
  localparam int FLG_CONSOLE  = 8;

  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] IMASK_RST = 16'h0000;
  localparam logic [15:0] EMASK_RST = 16'h0000;
  localparam logic [15:0] GRPEN_RST = 16'h0000;

  // internal line numbers
  localparam logic [3:0] LINE_POWER  = 4'h0;
  localparam logic [3:0] LINE_PARITY = 4'h1;
  localparam logic [3:0] LINE_TAG    = 4'h3;

  // base of the per-line vector cells
  localparam logic [15:0] VEC_BASE = 16'h0010;

  typedef enum logic [1:0] {
    VK_LINK  = 2'b00,
    VK_EXEC  = 2'b01,
    VK_OTHER = 2'b10
  } pis_vkind_t;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_VEC = 1'b1
  } pis_state_t;

endpackage

// ---- pis_prio16.sv ----
`timescale 1ns/100ps
`default_nettype none
module pis_prio16
(
  input  wire logic [15:0] req,
  output logic             any,
  output logic [3:0]       idx
);

  // level 0 is the highest priority
  always_comb
  begin
    any = |req;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (req[i])
      begin
        idx = 4'(i);                                                   // R02
      end
    end
  end

endmodule
`default_nettype wire

// ---- pis_scanner.sv ----
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R01: watch 16 internal plus 256 external lines
// R02: internal priority fixed, power failure highest
// R03: group 0 internal, groups 1-16 external
// R04: earlier group and lower level win
// R05: sweep all groups at each cycle start
// R06: in service, only higher priority interrupts
// R07: break flow only at instruction boundary
// R08: tag/parity on fetch interrupt before execute
// R09: one enable flag gates whole system
// R10: power failure ignores enable and masks
// R11: two 16-bit masks, one recognises line
// R12: masks loaded whole; groups 2-16 per group
// R13: jump to fixed vector of winning line
// R14: vector instruction itself cannot be interrupted
// R15: link stores return address, handler follows
// R16: execute runs target, counter kept unless jump
// R17: other instruction runs, then resume program
// R18: 16-bit flags updated every instruction end
// R19: less, overflow sticky, carry, busy, enable, console
// R20: true/complement tests, zero from sense tests
// R21: flags stored and reloaded whole
// R22: internal requests latched until serviced
// R23: exactly one highest winner per boundary
module pis_scanner
  import pis_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  input  wire logic [15:0]              int_req,
  input  wire logic [PIS_EXT_LINES-1:0] ext_req,
  input  wire logic                     sweep_start,
  input  wire logic                     instr_done,
  input  wire logic                     fetch_fault,
  input  wire logic [15:0]              loc_counter,
  input  wire logic                     handler_return,
  input  wire logic                     load_flags_op,
  input  wire logic                     load_internal_mask_op,
  input  wire logic                     load_external_mask_op,
  input  wire logic                     status_function_line_op,
  input  wire logic [3:0]               sfl_group,
  input  wire logic                     sfl_enable,
  input  wire logic                     jump_set_enable_op,
  input  wire logic                     jump_reset_enable_op,
  input  wire logic                     link_reset_enable_op,
  input  wire logic [15:0]              op_data,
  input  wire logic                     acc_neg,
  input  wire logic                     acc_ovf,
  input  wire logic                     acc_carry,
  input  wire logic                     line_busy,
  input  wire logic                     result_zero,
  input  wire logic                     sense_test_op,
  input  wire logic                     sense_test_high,
  input  wire logic [7:0]               console_flags,
  input  wire logic [3:0]               flag_test_sel,
  input  wire logic                     flag_test_invert,
  input  wire logic                     vec_done,
  input  wire logic [1:0]               vec_kind,
  input  wire logic [15:0]              vec_target,
  input  wire logic                     vec_target_jump,
  input  wire logic [15:0]              vec_jump_addr,
  output logic                          int_take,
  output logic [15:0]                   int_vector,
  output logic [PIS_LINE_W-1:0]         int_line,
  output logic                          in_service,
  output logic                          vec_immune,
  output logic                          link_store,
  output logic [15:0]                   link_store_addr,
  output logic [15:0]                   link_store_data,
  output logic                          resume_valid,
  output logic [15:0]                   resume_addr,
  output logic [15:0]                   condition_flags,
  output logic [15:0]                   internal_line_mask,
  output logic [15:0]                   external_line_mask,
  output logic                          flag_test_true
);

  ////////////////////////////////////////////////////////////////////////////
  // masking and scan

  logic [15:0]            pend_r;
  logic [15:0]            pend_nxt;
  logic [15:0]            flags_r;
  logic [15:0]            flags_nxt;
  logic [15:0]            imask_r;
  logic [15:0]            imask_nxt;
  logic [15:0]            emask_r;
  logic [15:0]            emask_nxt;
  logic [15:0]            grpen_r;
  logic [15:0]            grpen_nxt;
  logic [PIS_GROUPS-1:0]  g_any;
  logic [3:0]             g_idx [PIS_GROUPS];
  logic [15:0]            g_req [PIS_GROUPS];
  logic                   scan_any;
  logic [PIS_LINE_W-1:0]  scan_line;
  logic                   ena;

  assign ena = flags_r[FLG_ENABLE];

  always_comb
  begin
    g_req[0] = pend_r & imask_r & {16{ena}};                           // R09 R11
    g_req[0][LINE_POWER] = pend_r[LINE_POWER];                         // R10
    g_req[1] = ext_req[15:0] & emask_r & {16{ena}};                    // R11
    for (int g = 2; g < PIS_GROUPS; g++)
    begin
      g_req[g] = ext_req[(g-1)*16 +: 16] & {16{ena & grpen_r[g-1]}};   // R12
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIS_GROUPS; gi++)
    begin : g_enc
      pis_prio16 u_enc
      (
        .req (g_req[gi]),
        .any (g_any[gi]),
        .idx (g_idx[gi])
      );
    end
  endgenerate

  // lowest group wins, so a single line is chosen
  always_comb
  begin
    scan_any  = |g_any;                                                // R04 R23
    scan_line = '0;
    for (int g = PIS_GROUPS - 1; g >= 0; g--)
    begin
      if (g_any[g])
      begin
        scan_line = PIS_LINE_W'(g * 16) + PIS_LINE_W'(g_idx[g]);       // R03
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  pis_state_t             state_r;
  pis_state_t             state_nxt;
  logic                   win_vld_r;
  logic                   win_vld_nxt;
  logic [PIS_LINE_W-1:0]  win_line_r;
  logic [PIS_LINE_W-1:0]  win_line_nxt;
  logic                   srv_r;
  logic                   srv_nxt;
  logic [PIS_LINE_W-1:0]  srv_line_r;
  logic [PIS_LINE_W-1:0]  srv_line_nxt;
  logic [15:0]            save_lc_r;
  logic [15:0]            save_lc_nxt;
  logic                   take_nxt;
  logic                   take_r;
  logic [15:0]            vec_nxt;
  logic [15:0]            vec_r;
  logic                   lst_nxt;
  logic                   lst_r;
  logic [15:0]            lsa_nxt;
  logic [15:0]            lsa_r;
  logic                   res_nxt;
  logic                   res_r;
  logic [15:0]            resa_nxt;
  logic [15:0]            resa_r;
  logic                   allowed;
  logic                   fetch_hit;
  logic                   take_now;

  // single nesting level: a lower handler is not remembered under a higher one
  assign allowed   = win_vld_r && (!srv_r || win_line_r < srv_line_r);                        // R06
  assign fetch_hit = fetch_fault && allowed &&
                     (win_line_r == PIS_LINE_W'(LINE_PARITY) || win_line_r == PIS_LINE_W'(LINE_TAG)); // R08
  assign take_now  = (state_r == ST_RUN) && ((instr_done && allowed) || fetch_hit);           // R07 R14

  always_comb
  begin
    state_nxt    = state_r;
    win_vld_nxt  = win_vld_r;
    win_line_nxt = win_line_r;
    srv_nxt      = srv_r;
    srv_line_nxt = srv_line_r;
    save_lc_nxt  = save_lc_r;
    take_nxt     = 1'b0;
    vec_nxt      = vec_r;
    lst_nxt      = 1'b0;
    lsa_nxt      = lsa_r;
    res_nxt      = 1'b0;
    resa_nxt     = resa_r;
    if (sweep_start)
    begin
      win_vld_nxt  = scan_any;                                         // R05
      win_line_nxt = scan_line;
    end
    if (handler_return)
    begin
      srv_nxt = 1'b0;
    end
    case (state_r)
      ST_RUN:
      begin
        if (take_now)
        begin
          take_nxt     = 1'b1;
          vec_nxt      = VEC_BASE + 16'(win_line_r);                   // R13
          save_lc_nxt  = loc_counter;
          srv_nxt      = 1'b1;
          srv_line_nxt = win_line_r;
          win_vld_nxt  = 1'b0;
          state_nxt    = ST_VEC;
        end
      end
      ST_VEC:
      begin
        win_vld_nxt = 1'b0;                                            // R14
        if (vec_done)
        begin
          state_nxt = ST_RUN;
          res_nxt   = 1'b1;
          case (vec_kind)
            VK_LINK:
            begin
              lst_nxt  = 1'b1;                                         // R15
              lsa_nxt  = vec_target;
              resa_nxt = vec_target + 16'h0001;
            end
            VK_EXEC:
            begin
              resa_nxt = vec_target_jump ? vec_jump_addr : save_lc_r;  // R16
            end
            default:
            begin
              resa_nxt = save_lc_r;                                    // R17
            end
          endcase
        end
      end
      default:
      begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r    <= ST_RUN;
      win_vld_r  <= 1'b0;
      win_line_r <= '0;
      srv_r      <= 1'b0;
      srv_line_r <= '0;
      save_lc_r  <= 16'h0000;
      take_r     <= 1'b0;
      vec_r      <= 16'h0000;
      lst_r      <= 1'b0;
      lsa_r      <= 16'h0000;
      res_r      <= 1'b0;
      resa_r     <= 16'h0000;
    end
    else
    begin
      state_r    <= state_nxt;
      win_vld_r  <= win_vld_nxt;
      win_line_r <= win_line_nxt;
      srv_r      <= srv_nxt;
      srv_line_r <= srv_line_nxt;
      save_lc_r  <= save_lc_nxt;
      take_r     <= take_nxt;
      vec_r      <= vec_nxt;
      lst_r      <= lst_nxt;
      lsa_r      <= lsa_nxt;
      res_r      <= res_nxt;
      resa_r     <= resa_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending latches, masks and flags

  always_comb
  begin
    pend_nxt = pend_r;
    if (take_now && win_line_r < PIS_LINE_W'(PIS_LEVELS))
    begin
      pend_nxt[win_line_r[3:0]] = 1'b0;
    end
    pend_nxt = pend_nxt | int_req;                                     // R01 R22
    imask_nxt = load_internal_mask_op ? op_data : imask_r;             // R12
    emask_nxt = load_external_mask_op ? op_data : emask_r;             // R12
    grpen_nxt = grpen_r;
    if (status_function_line_op && sfl_group != 4'h0)
    begin
      grpen_nxt[sfl_group] = sfl_enable;                               // R12
    end
    flags_nxt = flags_r;
    if (instr_done)
    begin
      flags_nxt[FLG_LESS]  = acc_neg;                                  // R18 R19
      flags_nxt[FLG_OVF]   = flags_r[FLG_OVF] | acc_ovf;
      flags_nxt[FLG_CARRY] = acc_carry;
      flags_nxt[FLG_BUSY]  = line_busy;
      flags_nxt[FLG_ZERO]  = sense_test_op ? sense_test_high : result_zero; // R20
      flags_nxt[FLG_CONSOLE +: 8] = console_flags;
    end
    if (jump_set_enable_op)
    begin
      flags_nxt[FLG_ENABLE] = 1'b1;                                    // R09
    end
    if (jump_reset_enable_op || link_reset_enable_op)
    begin
      flags_nxt[FLG_ENABLE] = 1'b0;                                    // R09
    end
    if (load_flags_op)
    begin
      flags_nxt = op_data;                                             // R21
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_r  <= 16'h0000;
      flags_r <= FLAGS_RST;
      imask_r <= IMASK_RST;
      emask_r <= EMASK_RST;
      grpen_r <= GRPEN_RST;
    end
    else
    begin
      pend_r  <= pend_nxt;
      flags_r <= flags_nxt;
      imask_r <= imask_nxt;
      emask_r <= emask_nxt;
      grpen_r <= grpen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign int_take           = take_r;
  assign int_vector         = vec_r;
  assign int_line           = srv_line_r;
  assign in_service         = srv_r;
  assign vec_immune         = (state_r == ST_VEC);
  assign link_store         = lst_r;
  assign link_store_addr    = lsa_r;
  assign link_store_data    = save_lc_r;
  assign resume_valid       = res_r;
  assign resume_addr        = resa_r;
  assign condition_flags    = flags_r;
  assign internal_line_mask = imask_r;
  assign external_line_mask = emask_r;
  assign flag_test_true     = flags_r[flag_test_sel] ^ flag_test_invert; // R20

endmodule
`default_nettype wire

// ---- pis_scanner_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module pis_scanner_props
  import pis_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  rstn,
  input wire logic                  instr_done,
  input wire logic                  fetch_fault,
  input wire logic                  vec_done,
  input wire logic [1:0]            vec_kind,
  input wire logic [15:0]           vec_target,
  input wire logic                  vec_target_jump,
  input wire logic [15:0]           vec_jump_addr,
  input wire logic [15:0]           link_store_data,
  input wire logic [15:0]           op_data,
  input wire logic                  load_flags_op,
  input wire logic [3:0]            flag_test_sel,
  input wire logic                  flag_test_invert,
  input wire logic                  int_take,
  input wire logic [15:0]           int_vector,
  input wire logic [PIS_LINE_W-1:0] int_line,
  input wire logic                  in_service,
  input wire logic                  vec_immune,
  input wire logic                  link_store,
  input wire logic [15:0]           link_store_addr,
  input wire logic                  resume_valid,
  input wire logic [15:0]           resume_addr,
  input wire logic [15:0]           condition_flags,
  input wire logic                  flag_test_true
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  take_vector_a: assert property (int_take |-> int_vector == VEC_BASE + {7'h00, int_line})
    else $error("vector is not base plus line");
  take_boundary_a: assert property (int_take |-> $past(instr_done | fetch_fault))
    else $error("take away from a boundary");
  take_state_a: assert property (int_take |-> in_service && vec_immune)
    else $error("take without service state");
  vec_immune_a: assert property (vec_immune && !vec_done |=> !int_take)
    else $error("take during vector instruction");
  link_entry_a: assert property (vec_done && vec_immune && vec_kind == VK_LINK |=> link_store
    && link_store_addr == $past(vec_target) && resume_addr == $past(vec_target) + 16'h0001)
    else $error("link entry wrong");
  other_entry_a: assert property (vec_done && vec_immune && vec_kind == VK_OTHER |=>
    resume_valid && !link_store && !vec_immune)
    else $error("other entry wrong");
  exec_entry_a: assert property (vec_done && vec_immune && vec_kind == VK_EXEC |=> resume_valid && !link_store
    && resume_addr == ($past(vec_target_jump) ? $past(vec_jump_addr) : link_store_data))
    else $error("execute entry wrong");
  flag_test_a: assert property (flag_test_true == (condition_flags[flag_test_sel] ^ flag_test_invert))
    else $error("flag test sense wrong");
  flag_load_a: assert property (load_flags_op |=> condition_flags == $past(op_data))
    else $error("flag load lost");
endmodule
`default_nettype wire

// ---- pis_seq_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pis_seq_model
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        vec_immune,
  input  wire logic        instr_hold,
  input  wire logic [1:0]  kind_sel,
  output logic             sweep_start,
  output logic             instr_done,
  output logic             vec_done,
  output logic [1:0]       vec_kind,
  output logic [15:0]      vec_target,
  output logic [15:0]      loc_counter
);
  logic [1:0] ph_r;
  ////////////////////////////////////////
  // four phases: sweep, boundary, idle, vector slot
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      ph_r <= 2'h0;
      loc_counter <= 16'h0200;
    end
    else
    begin
      ph_r <= ph_r + 2'h1;
      if (instr_done)
        loc_counter <= loc_counter + 16'h0001;
    end
  assign sweep_start = (ph_r == 2'h0);
  // no boundary while the vector instruction runs
  // hold models a long instruction, so only a fetch fault can break in
  assign instr_done = (ph_r == 2'h1) && !vec_immune && !instr_hold;
  assign vec_done = (ph_r == 2'h3) && vec_immune;
  assign vec_kind = kind_sel;
  assign vec_target = 16'h0100;
endmodule
`default_nettype wire

// ---- priority_interrupt_scanner_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_scanner_bench
  import pis_pkg::*;
();
  typedef struct packed {
    logic [15:0] ir;
    logic [8:0]  ei;
    logic [15:0] im;
    logic [15:0] em;
    logic        e;
    logic [3:0]  sg;
    logic [8:0]  exp;
  } pis_row_t;
  logic         ref_clk, rstn, handler_return, load_flags_op, load_internal_mask_op, load_external_mask_op;
  logic         status_function_line_op, sfl_enable, jump_set_enable_op, jump_reset_enable_op;
  logic         link_reset_enable_op, acc_neg, acc_ovf, acc_carry, sense_test_op, sense_test_high;
  logic         flag_test_invert, sweep_start, instr_done, vec_done, int_take, in_service, vec_immune;
  logic         link_store, resume_valid, flag_test_true;
  logic         fetch_fault, vec_target_jump, line_busy, result_zero, instr_hold;
  logic [15:0]  vec_jump_addr;
  logic [1:0]   vec_kind, kind_sel;
  logic [3:0]   sfl_group, flag_test_sel;
  logic [7:0]   console_flags;
  logic [8:0]   int_line, ln;
  logic [15:0]  int_req, op_data, loc_counter, vec_target, int_vector, link_store_addr, link_store_data;
  logic [15:0]  resume_addr, condition_flags, internal_line_mask, external_line_mask;
  logic [255:0] ext_req;
  int           fails, n_compared;
  bit           got;
  // ext index bit 8 means no external line; expected 1FF means no take
  pis_row_t rows [10] = '{
    '{16'h0040, 9'h100, 16'h0040, 16'h0000, 1'b1, 4'h0, 9'h006},
    '{16'h0048, 9'h100, 16'hFFFF, 16'h0000, 1'b1, 4'h0, 9'h003},
    '{16'h0040, 9'h100, 16'h0000, 16'h0000, 1'b1, 4'h0, 9'h1FF},
    '{16'h0040, 9'h100, 16'hFFFF, 16'h0000, 1'b0, 4'h0, 9'h1FF},
    '{16'h0001, 9'h100, 16'h0000, 16'h0000, 1'b0, 4'h0, 9'h000},
    '{16'h0000, 9'h005, 16'h0000, 16'h0020, 1'b1, 4'h0, 9'h015},
    '{16'h0100, 9'h000, 16'hFFFF, 16'hFFFF, 1'b1, 4'h0, 9'h008},
    '{16'h0000, 9'h000, 16'hFFFF, 16'h0000, 1'b1, 4'h0, 9'h1FF},
    '{16'h0000, 9'h010, 16'h0000, 16'h0000, 1'b1, 4'h1, 9'h020},
    '{16'h0000, 9'h0FF, 16'h0000, 16'h0000, 1'b1, 4'hF, 9'h10F}};
  pis_scanner pis_scanner_inst (.*);
  pis_seq_model pis_seq_model_inst (.*);
  ////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want)
    begin
      fails++;
      $display("Error at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask
  task automatic ld(input int w, input logic [15:0] d);
    @(posedge ref_clk);
    op_data <= d;
    {load_flags_op, load_internal_mask_op, load_external_mask_op} <= {w == 0, w == 1, w == 2};
    @(posedge ref_clk);
    {load_flags_op, load_internal_mask_op, load_external_mask_op} <= 3'h0;
    #1;
  endtask
  task automatic irq(input logic [15:0] v);
    @(posedge ref_clk);
    int_req <= v;
    @(posedge ref_clk);
    int_req <= 16'h0000;
  endtask
  // fixed span so that a refused request is seen as no take at all
  task automatic wait_take(input logic [15:0] want);
    got = 1'b0;
    repeat (24)
    begin
      @(posedge ref_clk);
      #1;
      if (!got && int_take === 1'b1)
        {got, ln} = {1'b1, int_line};
    end
    chk({7'h00, got ? ln : 9'h1FF}, want);
  endtask
  task automatic en(input logic [2:0] ops, input logic want);
    @(posedge ref_clk);
    {jump_set_enable_op, jump_reset_enable_op, link_reset_enable_op} <= ops;
    @(posedge ref_clk);
    {jump_set_enable_op, jump_reset_enable_op, link_reset_enable_op} <= 3'h0;
    #1;
    chk({15'h0000, condition_flags[FLG_ENABLE]}, {15'h0000, want});
  endtask
  ////////////////////////////////////////
  initial
  begin
    {int_req, ext_req, op_data, sfl_group, console_flags, flag_test_sel, kind_sel} = '0;
    {handler_return, load_flags_op, load_internal_mask_op, load_external_mask_op, sfl_enable} = '0;
    {status_function_line_op, jump_set_enable_op, jump_reset_enable_op, link_reset_enable_op} = '0;
    {acc_neg, acc_ovf, acc_carry, sense_test_op, sense_test_high, flag_test_invert} = '0;
    {fetch_fault, vec_target_jump, line_busy, result_zero, instr_hold, vec_jump_addr} = '0;
    {rstn, fails, n_compared} = '0;
    foreach (rows[i])
    begin
      do_reset();
      kind_sel <= 2'(i % 3);
      {vec_target_jump, vec_jump_addr} <= {i[0], 16'h0300};
      ld(1, rows[i].im);
      ld(2, rows[i].em);
      ld(0, {11'h000, rows[i].e, 4'h0});
      @(posedge ref_clk);
      {status_function_line_op, sfl_enable, sfl_group} <= {rows[i].sg != 4'h0, 1'b1, rows[i].sg};
      int_req <= rows[i].ir;
      ext_req <= rows[i].ei[8] ? 256'h0 : (256'h1 << rows[i].ei[7:0]);
      @(posedge ref_clk);
      {status_function_line_op, int_req} <= '0;
      wait_take({7'h00, rows[i].exp});
      ext_req <= 256'h0;
      $display("row %0d done", i);
    end
    do_reset();
    @(posedge ref_clk);
    #1;
    chk(condition_flags | internal_line_mask | external_line_mask, FLAGS_RST | IMASK_RST | EMASK_RST);
    ld(1, 16'hFFFF);
    ld(0, 16'h0010);
    irq(16'h0040);
    wait_take(16'h0006);
    irq(16'h0080);
    wait_take(16'h01FF);
    irq(16'h0008);
    wait_take(16'h0003);
    @(posedge ref_clk);
    handler_return <= 1'b1;
    @(posedge ref_clk);
    handler_return <= 1'b0;
    wait_take(16'h0007);
    $display("nesting done");
    do_reset();
    ld(1, 16'hFFFF);
    ld(0, 16'h0010);
    @(posedge ref_clk);
    instr_hold <= 1'b1;
    irq(16'h0010);
    wait_take(16'h01FF);
    irq(16'h0002);
    fetch_fault <= 1'b1;
    wait_take(16'h0001);
    {fetch_fault, instr_hold} <= 2'b00;
    $display("fetch done");
    do_reset();
    @(posedge ref_clk);
    {acc_neg, acc_ovf, acc_carry, line_busy, sense_test_op, sense_test_high, console_flags} <= {6'h3F, 8'hA5};
    flag_test_sel <= 4'(FLG_OVF);
    repeat (8) @(posedge ref_clk);
    #1;
    chk(condition_flags, 16'hA52F);
    chk({15'h0000, flag_test_true}, 16'h0001);
    {acc_neg, acc_ovf, acc_carry, line_busy, sense_test_op, sense_test_high, console_flags} <= '0;
    {result_zero, flag_test_invert} <= 2'b11;
    repeat (8) @(posedge ref_clk);
    #1;
    chk(condition_flags, 16'h0022);
    chk({15'h0000, flag_test_true}, 16'h0000);
    ld(0, 16'h0000);
    chk(condition_flags, 16'h0000);
    en(3'b100, 1'b1);
    en(3'b110, 1'b0);
    en(3'b100, 1'b1);
    en(3'b001, 1'b0);
    $display("flags done");
    finish_test();
  end
  // about seven times the expected run
  initial
  begin
    #400000;
    fails++;
    finish_test();
  end
endmodule
bind pis_scanner pis_scanner_props pis_scanner_props_inst (.*);
`default_nettype wire
